/* File: shared/rmx_pkg.sv */
// Constants, types and helpers for the remote message exchange block
// What this block does
// - A message is items split by semicolons, closed by a terminator
// - Terminal mode ends a message on CR, LF or CR followed by LF
// - Computer mode ends a message only on LF
// - Bus mode ends a message on LF or any byte sent with EOI
// - Terminal mode runs a message only after its terminator, in order
// - Terminal mode drops bytes into a full buffer and flags an error
// - Bus and computer modes refuse input while the buffer is full
// - Replies are produced only for queries
// - Serial modes send replies at once; bus mode waits for talk
// - A new message discards an unread reply and flags an error
// - One reply unit per query, units split by semicolons
// - Reply ends CR LF, LF, or LF with EOI by mode
// - Entering remote clears pattern or jitter conflicts
// - A conflicting setting is refused and flagged
// - Coupled settings are applied together at message end
// - Items run strictly one after another
// - Operation complete follows only finished items
// - Input buffer holds 100 bytes; outside terminal mode parsing runs while bytes arrive
// - Headers are accepted in upper or lower case
// - Each query builds its reply when parsed
package rmx_pkg;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7a;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam int IN_DEPTH = 100;
  localparam int OUT_DEPTH = 16;
  localparam int IN_W = 9;
  localparam int OUT_W = 9;
  localparam int MCNT_W = 7;

  typedef enum logic [1:0] {
    MODE_TERM = 2'h0,
    MODE_COMP = 2'h1,
    MODE_GPIB = 2'h2
  } rmx_mode_t;

  function automatic logic [7:0] rmx_upcase(input logic [7:0] b);
    if (b >= CH_LA && b <= CH_LZ) begin
      return b - CASE_OFS;
    end
    return b;
  endfunction

  function automatic logic rmx_is_term(input rmx_mode_t m,
                                       input logic [7:0] b,
                                       input logic eoi);
    case (m)
      MODE_TERM: return b == CH_CR || b == CH_LF;
      MODE_COMP: return b == CH_LF;
      MODE_GPIB: return b == CH_LF || eoi;
      default: return 1'b0;
    endcase
  endfunction
endpackage

/* File: logic/rmx_fifo.sv */
// Synchronous FIFO with flush, used for the input buffer and reply queue
`timescale 1ns/1ps
module rmx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  import rmx_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } rmx_fifo_st_t;

  rmx_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = s_q.cnt != CW'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = mem[s_q.rp];
  assign level = s_q.cnt;
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d = '0;
    end else begin
      if (push) begin
        s_d.wp = nxt(s_q.wp);
      end
      if (pop) begin
        s_d.rp = nxt(s_q.rp);
      end
      s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[s_q.wp] <= in_data;
    end
  end
endmodule

/* File: logic/rmx_msg_exchange.sv */
// Program message parser, sequencer and reply formatter
`timescale 1ns/1ps
module rmx_msg_exchange (
  input wire logic mclk,
  input wire logic rst_b,
  input wire rmx_pkg::rmx_mode_t mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eoi,
  output logic rx_ready,
  input wire logic talk_en,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_eoi,
  input wire logic tx_ready,
  output logic hdr_valid,
  output logic [7:0] hdr_byte,
  output logic exec_req,
  output logic exec_query,
  input wire logic exec_done,
  input wire logic exec_coupled,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  output logic op_complete,
  output logic apply_req,
  input wire logic apply_done,
  input wire logic contention_hit,
  output logic contention_err,
  input wire logic pat_contention,
  input wire logic jit_contention,
  output logic force_prbs15_sync,
  output logic force_jitter_off,
  output logic remote_active,
  output logic overrun_err,
  output logic reply_cut_off_error
);
  import rmx_pkg::*;
  localparam int IN_LW = $clog2(IN_DEPTH + 1);
  localparam int OUT_LW = $clog2(OUT_DEPTH + 1);

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_EXEC = 6'b00_0010,
    S_END = 6'b00_0100,
    S_APPLY = 6'b00_1000,
    S_TCR = 6'b01_0000,
    S_TLF = 6'b10_0000
  } rmx_state_t;

  typedef struct packed {
    rmx_state_t st;
    logic [MCNT_W-1:0] msg_cnt;
    logic item;
    logic query;
    logic eom;
    logic pend_apply;
    logic any_unit;
    logic unit_open;
    logic remote;
    logic after_cr;
    logic msg_start;
    logic hdr_v;
    logic [7:0] hdr_b;
    logic exec_req;
    logic op_done;
    logic apply_req;
    logic c_err;
    logic force_p;
    logic force_j;
    logic ovr;
    logic cut;
  } rmx_st_t;

  rmx_st_t s_q, s_d;

  logic in_rdy, in_v, in_wr, in_pop, rx_term, skip_lf;
  logic [IN_W-1:0] in_word;
  logic [IN_LW-1:0] in_lvl;
  logic out_rdy, out_v, out_push, out_flush, out_pop;
  logic [OUT_W-1:0] out_word, out_head;
  logic [OUT_LW-1:0] out_lvl;
  logic [7:0] pb;
  logic w_term, w_crlf, w_data, w_end, need_sep;

  assign rx_term = rmx_is_term(mode, rx_data, rx_eoi);
  // A lone LF after CR closes nothing new in terminal mode
  assign skip_lf = mode == MODE_TERM && s_q.after_cr && rx_data == CH_LF;
  // Terminal mode always takes bytes, losing them when full
  assign rx_ready = (mode == MODE_TERM) ? 1'b1 : in_rdy;
  assign in_wr = rx_valid && !skip_lf && in_rdy;

  // Terminal mode holds parsing until a whole message sits in the buffer
  assign in_pop = s_q.st == S_IDLE && in_v &&
                  (mode != MODE_TERM || s_q.msg_cnt != '0);

  assign w_term = in_word[IN_W-1];
  assign pb = rmx_upcase(in_word[7:0]);
  assign w_crlf = pb == CH_CR || pb == CH_LF;
  assign w_data = pb != CH_SEMI && !w_crlf;
  assign w_end = pb == CH_SEMI || w_term;

  assign need_sep = s_q.any_unit && !s_q.unit_open;
  // Replies are taken only while a query is being run
  assign resp_ready = s_q.st == S_EXEC && s_q.query && out_rdy &&
                      !need_sep;

  // Serial replies leave at once; bus replies wait to be talked out
  assign out_pop = tx_ready && (mode != MODE_GPIB || talk_en);
  assign tx_valid = out_v && (mode != MODE_GPIB || talk_en);
  assign tx_data = out_head[7:0];
  assign tx_eoi = out_head[OUT_W-1];

  assign hdr_valid = s_q.hdr_v;
  assign hdr_byte = s_q.hdr_b;
  assign exec_req = s_q.exec_req;
  assign exec_query = s_q.query;
  assign op_complete = s_q.op_done;
  assign apply_req = s_q.apply_req;
  assign contention_err = s_q.c_err;
  assign force_prbs15_sync = s_q.force_p;
  assign force_jitter_off = s_q.force_j;
  assign remote_active = s_q.remote;
  assign overrun_err = s_q.ovr;
  assign reply_cut_off_error = s_q.cut;

  // Input buffer of 100 bytes; outside terminal mode parsing drains it while bytes arrive
  rmx_fifo #(.WIDTH(IN_W), .DEPTH(IN_DEPTH)) u_in_buf (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(1'b0),
    .in_valid(in_wr),
    .in_data({rx_term, rx_data}),
    .in_ready(in_rdy),
    .out_valid(in_v),
    .out_data(in_word),
    .out_ready(in_pop),
    .level(in_lvl)
  );

  rmx_fifo #(.WIDTH(OUT_W), .DEPTH(OUT_DEPTH)) u_out_q (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(out_flush),
    .in_valid(out_push),
    .in_data(out_word),
    .in_ready(out_rdy),
    .out_valid(out_v),
    .out_data(out_head),
    .out_ready(out_pop),
    .level(out_lvl)
  );

  always_comb begin
    s_d = s_q;
    s_d.hdr_v = 1'b0;
    s_d.exec_req = 1'b0;
    s_d.op_done = 1'b0;
    s_d.apply_req = 1'b0;
    s_d.c_err = 1'b0;
    s_d.force_p = 1'b0;
    s_d.force_j = 1'b0;
    s_d.ovr = 1'b0;
    s_d.cut = 1'b0;
    out_push = 1'b0;
    out_word = '0;
    out_flush = 1'b0;

    if (rx_valid && rx_ready) begin
      s_d.after_cr = rx_data == CH_CR;
    end
    if (rx_valid && mode == MODE_TERM && !skip_lf && !in_rdy) begin
      s_d.ovr = 1'b1;
    end
    if (in_wr) begin
      s_d.msg_start = rx_term;
      // Start of a new message while a reply still waits
      if (s_q.msg_start && out_lvl != '0) begin
        out_flush = 1'b1;
        s_d.cut = 1'b1;
      end
    end
    s_d.msg_cnt = s_q.msg_cnt +
      MCNT_W'(in_wr && rx_term && mode == MODE_TERM) -
      MCNT_W'(in_pop && w_term && s_q.msg_cnt != '0);

    case (s_q.st)
      S_IDLE: begin
        if (in_pop) begin
          if (!s_q.remote) begin
            s_d.remote = 1'b1;
            s_d.force_p = pat_contention;
            s_d.force_j = jit_contention;
          end
          if (w_data) begin
            s_d.hdr_v = 1'b1;
            s_d.hdr_b = pb;
            s_d.item = 1'b1;
            if (pb == CH_QM) begin
              s_d.query = 1'b1;
            end
          end
          if (w_end) begin
            s_d.eom = w_term;
            if (s_q.item || w_data) begin
              s_d.exec_req = 1'b1;
              s_d.st = S_EXEC;
            end else if (w_term) begin
              s_d.st = S_END;
            end
          end
        end
      end
      S_EXEC: begin
        if (resp_valid && need_sep && out_rdy) begin
          out_push = 1'b1;
          out_word = {1'b0, CH_SEMI};
          s_d.unit_open = 1'b1;
        end else if (resp_valid && resp_ready) begin
          out_push = 1'b1;
          out_word = {1'b0, resp_data};
          s_d.unit_open = !resp_last;
          if (resp_last) begin
            s_d.any_unit = 1'b1;
          end
        end
        if (exec_done) begin
          s_d.op_done = 1'b1;
          // Coupled items are held and applied once the message is read
          s_d.pend_apply = s_q.pend_apply || exec_coupled;
          s_d.item = 1'b0;
          s_d.query = 1'b0;
          s_d.unit_open = 1'b0;
          s_d.st = s_q.eom ? S_END : S_IDLE;
        end
      end
      S_END: begin
        if (s_q.pend_apply) begin
          s_d.apply_req = 1'b1;
          s_d.pend_apply = 1'b0;
          s_d.st = S_APPLY;
        end else if (s_q.any_unit) begin
          s_d.st = (mode == MODE_TERM) ? S_TCR : S_TLF;
        end else begin
          s_d.st = S_IDLE;
        end
      end
      S_APPLY: begin
        if (apply_done) begin
          // Prior setting stays; only the flag is raised
          s_d.c_err = contention_hit;
          s_d.st = S_END;
        end
      end
      S_TCR: begin
        if (out_rdy) begin
          out_push = 1'b1;
          out_word = {1'b0, CH_CR};
          s_d.st = S_TLF;
        end
      end
      S_TLF: begin
        if (out_rdy) begin
          out_push = 1'b1;
          out_word = {mode == MODE_GPIB, CH_LF};
          s_d.any_unit = 1'b0;
          s_d.st = S_IDLE;
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.msg_start <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  a_no_unsolicited: assert property (@(posedge mclk) disable iff (!rst_b)
    out_push |-> (s_q.st == S_EXEC && s_q.query) || s_q.any_unit)
    else $error("Reply byte queued without a query");

  a_term_overrun: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == MODE_TERM && rx_valid && !skip_lf && !in_rdy) |=> overrun_err)
    else $error("Dropped byte not flagged");

  a_full_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode != MODE_TERM && in_lvl == IN_LW'(IN_DEPTH)) |-> !rx_ready)
    else $error("Full buffer still accepting");

  a_bus_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == MODE_GPIB && !talk_en) |-> !tx_valid)
    else $error("Bus reply sent while not talker");

  a_cut_off: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_wr && s_q.msg_start && out_lvl != '0) |=> reply_cut_off_error
      ##1 !reply_cut_off_error)
    else $error("Interrupted reply not reported");

  a_term_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode == MODE_TERM && s_q.msg_cnt == '0) |-> !in_pop)
    else $error("Parsing before terminator");

  a_seq_exec: assert property (@(posedge mclk) disable iff (!rst_b)
    (s_q.st == S_EXEC && !exec_done) |=> !exec_req)
    else $error("Overlapping item issued");

  a_op_after: assert property (@(posedge mclk) disable iff (!rst_b)
    op_complete |-> $past(exec_done) && $past(s_q.st == S_EXEC))
    else $error("Completion without finished item");

  a_upcase_hdr: assert property (@(posedge mclk) disable iff (!rst_b)
    hdr_valid |-> !(hdr_byte >= CH_LA && hdr_byte <= CH_LZ))
    else $error("Header byte not folded to upper case");

  a_apply_end: assert property (@(posedge mclk) disable iff (!rst_b)
    apply_req |-> $past(s_q.st == S_END) ##1 !apply_req)
    else $error("Coupled apply outside message end");

  a_req_from_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    exec_req |-> s_q.st == S_EXEC && $past(s_q.st == S_IDLE))
    else $error("Item issued outside idle");

  a_bus_eoi_lf: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_valid && tx_eoi) |-> mode == MODE_GPIB && tx_data == CH_LF)
    else $error("End flag on a byte other than the bus terminator");

  a_remote_force: assert property (@(posedge mclk) disable iff (!rst_b)
    (force_prbs15_sync || force_jitter_off) |-> remote_active &&
      !$past(remote_active))
    else $error("Contention cleared outside remote entry");

  a_conflict_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    contention_err |-> $past(apply_done) && $past(contention_hit))
    else $error("Contention flagged without a failed apply");

  a_cut_empties: assert property (@(posedge mclk) disable iff (!rst_b)
    reply_cut_off_error |-> out_lvl == '0)
    else $error("Interrupted reply left in the queue");
endmodule

/* File: tb/rmx_eng_model.sv */
// Behavioural command engine that runs the items the block hands out
`timescale 1ns/1ps
module rmx_eng_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic exec_req,
  input wire logic exec_query,
  input wire logic resp_ready,
  input wire logic apply_req,
  input wire logic slow,
  input wire logic coupled,
  input wire logic conflict,
  output logic exec_done,
  output logic exec_coupled,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  output logic apply_done,
  output logic contention_hit
);
  initial begin
    {exec_done, exec_coupled, resp_valid, resp_last} = 4'h0;
    {apply_done, contention_hit} = 2'h0;
    resp_data = 8'h00;
    forever begin
      @(posedge mclk);
      if (rst_b && exec_req) begin
        if (exec_query) begin
          resp_valid <= 1'b1;
          resp_data <= 8'h37;
          resp_last <= 1'b1;
          do @(posedge mclk); while (!resp_ready && rst_b);
          resp_valid <= 1'b0;
          resp_last <= 1'b0;
          resp_data <= 8'hc8;
        end
        // Slow items let the input buffer fill up behind them
        repeat (slow ? 40 : 1) @(posedge mclk);
        exec_done <= 1'b1;
        exec_coupled <= coupled;
        @(posedge mclk);
        exec_done <= 1'b0;
        exec_coupled <= ~coupled;
      end
    end
  end
  always @(posedge mclk) begin
    apply_done <= rst_b && apply_req;
    contention_hit <= conflict;
  end
endmodule

/* File: tb/tb_remote_message_exchange.sv */
// Self-checking bench: random and corner messages in all three modes
`timescale 1ns/1ps
module tb_remote_message_exchange;
  import rmx_pkg::*;
  localparam int EX = 0, OPC = 1, TX = 2, CUT = 3, OVR = 4;
  localparam int APP = 5, CER = 6, PRB = 7, JIT = 8, EO = 9;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  rmx_mode_t mode = MODE_TERM;
  logic rx_valid = 1'b0, rx_eoi = 1'b0, talk_en = 1'b0, tx_ready = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic pat_contention = 1'b1, jit_contention = 1'b0;
  logic slow = 1'b0, coupled = 1'b0, conflict = 1'b0;
  logic rx_ready, tx_valid, tx_eoi, hdr_valid, exec_req, exec_query;
  logic exec_done, exec_coupled, resp_valid, resp_last, resp_ready;
  logic op_complete, apply_req, apply_done, contention_hit;
  logic contention_err, force_prbs15_sync, force_jitter_off;
  logic remote_active, overrun_err, reply_cut_off_error, te;
  logic [7:0] tx_data, hdr_byte, resp_data;
  logic [15:0] lf = 16'h0013;
  logic [9:0] ev;
  logic [7:0] hq[$], tq[$], xq[$];
  int cnt[10];
  int n_errors = 0, comparisons = 0, n_in = 0, full_at = -1;
  string s;

  always #12.5 mclk = ~mclk;

  rmx_msg_exchange rmx_msg_exchange_i (
    .mclk, .rst_b, .mode, .rx_valid, .rx_data, .rx_eoi, .rx_ready,
    .talk_en, .tx_valid, .tx_data, .tx_eoi, .tx_ready, .hdr_valid,
    .hdr_byte, .exec_req, .exec_query, .exec_done, .exec_coupled,
    .resp_valid, .resp_data, .resp_last, .resp_ready, .op_complete,
    .apply_req, .apply_done, .contention_hit, .contention_err,
    .pat_contention, .jit_contention, .force_prbs15_sync,
    .force_jitter_off, .remote_active, .overrun_err, .reply_cut_off_error
  );
  rmx_eng_model rmx_eng_model_i (
    .mclk, .rst_b, .exec_req, .exec_query, .resp_ready, .apply_req,
    .slow, .coupled, .conflict, .exec_done, .exec_coupled, .resp_valid,
    .resp_data, .resp_last, .apply_done, .contention_hit
  );

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  function automatic logic [7:0] letter();
    logic [7:0] l;
    l = 8'h41 + (rnd() % 8'h1a);
    return (rnd() & 8'h01) != 0 ? l | 8'h20 : l;
  endfunction
  function automatic logic [7:0] up(input logic [7:0] b);
    return (b >= 8'h61 && b <= 8'h7a) ? b - 8'h20 : b;
  endfunction

  // Counts pulses and collects streamed bytes; random sink stalls
  always @(posedge mclk) begin
    tx_ready <= ^rnd();
    ev = {tx_valid && tx_ready && tx_eoi, force_jitter_off,
          force_prbs15_sync, contention_err, apply_req, overrun_err,
          reply_cut_off_error, tx_valid && tx_ready, op_complete, exec_req};
    if (rst_b) begin
      if (hdr_valid) hq.push_back(hdr_byte);
      if (ev[TX]) tq.push_back(tx_data);
      if (ev[TX]) te = tx_eoi;
      foreach (cnt[i]) cnt[i] += int'(ev[i]);
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic clr();
    hq.delete();
    tq.delete();
    foreach (cnt[i]) cnt[i] = 0;
  endtask
  task automatic reset_to(input rmx_mode_t m);
    rst_b <= 1'b0;
    mode <= m;
    @(posedge mclk);
    clr();
    @(posedge mclk);
    rst_b <= 1'b1;
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    int k;
    k = 0;
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_eoi <= e;
    do begin
      @(posedge mclk);
      k++;
      if (!rx_ready && full_at < 0) full_at = n_in;
    end while (!rx_ready && k < 9000);
    if (!rx_ready) n_errors++;
    n_in++;
  endtask
  task automatic say(input string x, input logic e);
    for (int i = 0; i < x.len(); i++) put(x[i], e && i == x.len() - 1);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_eoi <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_n(input int i, input int w);
    int k;
    k = 0;
    while (cnt[i] < w && k < 9000) begin
      @(posedge mclk);
      k++;
    end
    if (cnt[i] < w) n_errors++;
    repeat (4) @(posedge mclk);
  endtask
  task automatic tx_is(input string x);
    chk("tx_count", tq.size(), x.len());
    for (int i = 0; i < x.len(); i++) chk("tx_byte", tq[i], x[i]);
  endtask
  // Separators, CR and LF never reach the header stream
  task automatic hdr_is(input string x);
    int j;
    j = 0;
    for (int i = 0; i < x.len(); i++) begin
      if (x[i] > 8'h20 && x[i] != 8'h3b) begin
        chk("hdr_byte", hq[j], up(x[i]));
        j++;
      end
    end
    chk("hdr_count", hq.size(), j);
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(25 * 30000);
    n_errors++;
    end_sim();
  end

  initial begin
    reset_to(MODE_TERM);
    chk("tx_valid", tx_valid, 0);
    chk("rx_ready", rx_ready, 1);
    s = "ab?;c\015\012";
    s.putc(0, letter());
    s.putc(1, letter());
    s.putc(4, letter());
    say(s.substr(0, 4), 1'b0);
    repeat (20) @(posedge mclk);
    chk("early_exec", cnt[EX], 0);
    say("\015\012", 1'b0);
    wait_n(TX, 3);
    tx_is("7\015\012");
    hdr_is(s);
    chk("items", cnt[EX], 2);
    chk("op_done", cnt[OPC], 2);
    chk("prbs_sync", cnt[PRB], 1);
    chk("jit_off", cnt[JIT], 0);
    chk("remote", remote_active, 1);
    pat_contention <= 1'b0;
    jit_contention <= 1'b1;
    reset_to(MODE_COMP);
    s = "x?\015;y?\012";
    say(s, 1'b0);
    wait_n(TX, 4);
    tx_is("7;7\012");
    hdr_is(s);
    chk("jit_off", cnt[JIT], 1);
    chk("prbs_sync", cnt[PRB], 0);
    reset_to(MODE_GPIB);
    say("q?", 1'b1);
    wait_n(OPC, 1);
    repeat (10) @(posedge mclk);
    chk("held_reply", cnt[TX], 0);
    talk_en <= 1'b1;
    wait_n(TX, 2);
    tx_is("7\012");
    chk("eoi_last", te, 1);
    chk("eoi_count", cnt[EO], 1);
    talk_en <= 1'b0;
    clr();
    say("q?\012", 1'b0);
    wait_n(OPC, 1);
    say("z\012", 1'b0);
    wait_n(OPC, 2);
    talk_en <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("cut_off", cnt[CUT], 1);
    chk("items", cnt[EX], 2);
    chk("stale_tx", cnt[TX], 0);
    coupled <= 1'b1;
    conflict <= 1'b1;
    clr();
    say("c;d\012", 1'b0);
    wait_n(CER, 1);
    chk("apply", cnt[APP], 1);
    chk("conflict", cnt[CER], 1);
    chk("no_reply", cnt[TX], 0);
    coupled <= 1'b0;
    conflict <= 1'b0;
    reset_to(MODE_COMP);
    slow <= 1'b1;
    full_at = -1;
    n_in = 0;
    for (int i = 0; i < 60; i++) begin
      xq.push_back(letter());
      put(xq[i], 1'b0);
      put(8'h3b, 1'b0);
    end
    say("\012", 1'b0);
    wait_n(OPC, 60);
    chk("fill_level", full_at >= 100 && full_at < 120, 1);
    chk("items", cnt[EX], 60);
    foreach (xq[i]) chk("hdr_byte", hq[i], up(xq[i]));
    chk("drained", rx_ready, 1);
    slow <= 1'b0;
    reset_to(MODE_TERM);
    full_at = -1;
    for (int i = 0; i < 105; i++) put(letter(), 1'b0);
    say("", 1'b0);
    repeat (4) @(posedge mclk);
    chk("dropped", cnt[OVR], 5);
    chk("refused", full_at, -1);
    chk("early_exec", cnt[EX], 0);
    reset_to(MODE_TERM);
    say("m?\012", 1'b0);
    wait_n(TX, 3);
    tx_is("7\015\012");
    chk("items", cnt[EX], 1);
    end_sim();
  end
endmodule
